/* File: rtl/csr_core_special_registers.sv */
// special-function register file of the execution core
// What this block does
// [RULE1] indirect port accesses go to the location held in their pointer
// [RULE2] indirect port a reaches sector 0 only, whatever its pointer holds
// [RULE3] indirect ports b and c reach any sector chosen by their sector pointer
// [RULE4] low pointer byte gives the location inside the selected sector
// [RULE5] indirect access landing on an indirect port does nothing
// [RULE6] all five pointers are ordinary readable, writable storage
// [RULE7] extended accesses carry 10 bits: sector above, location in low byte
// [RULE8] accumulator takes alu results; moves between registers pass through it
// [RULE9] writing program counter low byte jumps inside the current page
// [RULE10] such a jump inserts one dummy cycle
// [RULE11] table read loads high byte into table result, low byte to destination
// [RULE12] software writes change arithmetic flags, never power-down or watchdog flags
// [RULE13] signed compare flag is overflow xor result msb
// [RULE14] carry flag: add carry out, subtract no borrow, rotate through carry
// [RULE15] nibble carry: carry out of low nibble, or no nibble borrow
// [RULE16] zero flag set when result is zero
// [RULE17] overflow flag: carry into top bit differs from carry out
// [RULE18] power-down flag: cleared by reset or watchdog clear, set by halt
// [RULE19] watchdog flag: cleared by reset, clear or halt; set by time-out
// [RULE20] status flags are never saved automatically on call or interrupt
// [RULE21] flag updates land together with the instruction result write
`timescale 1ns/1ns
module csr_core_special_registers
	import csr_pkg::*;
(
	// clock and reset
	input  wire logic              clock,
	input  wire logic              reset_n,
	input  wire logic              clk_en,
	// data memory request from the execution core
	input  wire csr_req_t          req,
	output logic                   rsp_valid,
	output logic      [DATA_W-1:0] rsp_rdata,
	// data memory array outside
	output logic                   mem_en,
	output logic                   mem_we,
	output logic      [ADDR_W-1:0] mem_addr,
	output logic      [DATA_W-1:0] mem_wdata,
	input  wire logic [DATA_W-1:0] mem_rdata,
	// alu results
	input  wire csr_alu_t          alu,
	output logic      [DATA_W-1:0] accumulator,
	output logic      [DATA_W-1:0] status_flags,
	// program counter
	input  wire logic [PC_W-1:0]   pc_now,
	output logic                   pc_load,
	output logic      [PC_W-1:0]   pc_load_addr,
	output logic                   dummy_cycle,
	// look-up table
	output logic      [TBL_W-1:0]  table_addr,
	input  wire logic              prog_valid,
	input  wire logic [PWORD_W-1:0] prog_word,
	output logic                   table_done,
	output logic      [DATA_W-1:0] table_low_byte,
	// system events
	input  wire logic              watchdog_clear_instruction,
	input  wire logic              halt_instruction,
	input  wire logic              watchdog_timeout
);

	// ==========================================================
	// state
	logic [DATA_W-1:0] pointer_a_q;
	logic [DATA_W-1:0] pointer_b_low_q;
	logic [DATA_W-1:0] pointer_b_sector_q;
	logic [DATA_W-1:0] pointer_c_low_q;
	logic [DATA_W-1:0] pointer_c_sector_q;
	logic [DATA_W-1:0] acc_q;
	logic [DATA_W-1:0] table_pointer_low_q;
	logic [DATA_W-1:0] table_pointer_high_q;
	logic [DATA_W-1:0] table_result_high_q;
	logic [DATA_W-1:0] status_q;
	logic [DATA_W-1:0] status_d;
	logic              rsp_valid_q;
	logic [DATA_W-1:0] rsp_rdata_q;
	logic [DATA_W-1:0] rsp_rdata_d;
	logic              pc_load_q;
	logic [PC_W-1:0]   pc_load_addr_q;
	logic              table_done_q;
	logic [DATA_W-1:0] table_low_q;

	// ==========================================================
	// address decode
	function automatic csr_target_t decode(input logic [7:0] ofs);
		csr_target_t t;
		t = TGT_EXTERNAL;
		if (ofs == OFS_INDIRECT_PORT_A) begin
			t = TGT_IND_A;
		end else if (ofs == OFS_POINTER_A) begin
			t = TGT_PTR_A;
		end else if (ofs == OFS_INDIRECT_PORT_B) begin
			t = TGT_IND_B;
		end else if (ofs == OFS_POINTER_B_LOW) begin
			t = TGT_PTR_B_LOW;
		end else if (ofs == OFS_POINTER_B_SECTOR) begin
			t = TGT_PTR_B_SECT;
		end else if (ofs == OFS_ACCUMULATOR) begin
			t = TGT_ACC;
		end else if (ofs == OFS_PC_LOW_BYTE) begin
			t = TGT_PC_LOW;
		end else if (ofs == OFS_TABLE_POINTER_LOW) begin
			t = TGT_TBL_LOW;
		end else if (ofs == OFS_TABLE_RESULT_HIGH) begin
			t = TGT_TBL_RESULT;
		end else if (ofs == OFS_TABLE_POINTER_HI) begin
			t = TGT_TBL_HIGH;
		end else if (ofs == OFS_STATUS_FLAGS) begin
			t = TGT_STATUS;
		end else if (ofs == OFS_INDIRECT_PORT_C) begin
			t = TGT_IND_C;
		end else if (ofs == OFS_POINTER_C_LOW) begin
			t = TGT_PTR_C_LOW;
		end else if (ofs == OFS_POINTER_C_SECTOR) begin
			t = TGT_PTR_C_SECT;
		end
		return t;
	endfunction

	function automatic logic is_indirect(input csr_target_t t);
		return (t == TGT_IND_A) || (t == TGT_IND_B) || (t == TGT_IND_C);
	endfunction

	logic [ADDR_W-1:0] direct_addr;
	logic [ADDR_W-1:0] eff_addr;
	csr_target_t       first_tgt;
	csr_target_t       tgt;
	logic              no_op;
	logic              acc_ok;
	logic              wr_en;

	// standard instructions reach sector 0; special area overlaps every sector
	assign direct_addr = req.ext ? req.addr : {{SECT_W{1'b0}}, req.addr[7:0]}; // see [RULE7]
	assign first_tgt   = decode(req.addr[7:0]);

	always_comb begin
		eff_addr = direct_addr;
		case (first_tgt)
			TGT_IND_A: eff_addr = {{SECT_W{1'b0}}, pointer_a_q};                    // see [RULE2]
			TGT_IND_B: eff_addr = {pointer_b_sector_q[SECT_W-1:0], pointer_b_low_q}; // see [RULE3] [RULE4]
			TGT_IND_C: eff_addr = {pointer_c_sector_q[SECT_W-1:0], pointer_c_low_q}; // see [RULE3] [RULE4]
			default:   eff_addr = direct_addr;
		endcase
	end

	// a pointer that lands on an indirect port gives neither read nor write
	assign tgt    = is_indirect(first_tgt) ? decode(eff_addr[7:0]) : first_tgt; // see [RULE1]
	assign no_op  = is_indirect(first_tgt) && is_indirect(tgt);                   // see [RULE5]
	assign acc_ok = clk_en && req.valid && !no_op;
	assign wr_en  = acc_ok && req.write;

	// ==========================================================
	// data memory forwarding
	assign mem_en    = acc_ok && (tgt == TGT_EXTERNAL);
	assign mem_we    = wr_en && (tgt == TGT_EXTERNAL);
	assign mem_addr  = eff_addr;
	assign mem_wdata = req.wdata;

	// ==========================================================
	// read path, answered one cycle after the request
	always_comb begin
		rsp_rdata_d = 8'h00;
		case (tgt)
			TGT_EXTERNAL:   rsp_rdata_d = mem_rdata;
			TGT_PTR_A:      rsp_rdata_d = pointer_a_q;
			TGT_PTR_B_LOW:  rsp_rdata_d = pointer_b_low_q;
			TGT_PTR_B_SECT: rsp_rdata_d = pointer_b_sector_q;
			TGT_PTR_C_LOW:  rsp_rdata_d = pointer_c_low_q;
			TGT_PTR_C_SECT: rsp_rdata_d = pointer_c_sector_q;
			TGT_ACC:        rsp_rdata_d = acc_q;
			TGT_PC_LOW:     rsp_rdata_d = pc_now[7:0];
			TGT_TBL_LOW:    rsp_rdata_d = table_pointer_low_q;
			TGT_TBL_HIGH:   rsp_rdata_d = table_pointer_high_q;
			TGT_TBL_RESULT: rsp_rdata_d = table_result_high_q;
			TGT_STATUS:     rsp_rdata_d = status_q;
			default:        rsp_rdata_d = 8'h00;
		endcase
		if (no_op) begin
			rsp_rdata_d = 8'h00; // see [RULE5]
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			rsp_valid_q <= 1'b0;
			rsp_rdata_q <= RST_BYTE;
		end else if (clk_en) begin
			rsp_valid_q <= req.valid && !req.write;
			if (req.valid && !req.write) begin
				rsp_rdata_q <= rsp_rdata_d;
			end
		end
	end

	// ==========================================================
	// memory pointers
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			pointer_a_q        <= RST_BYTE;
			pointer_b_low_q    <= RST_BYTE;
			pointer_b_sector_q <= RST_BYTE;
			pointer_c_low_q    <= RST_BYTE;
			pointer_c_sector_q <= RST_BYTE;
		end else if (wr_en) begin
			case (tgt) // see [RULE6]
				TGT_PTR_A:      pointer_a_q        <= req.wdata;
				TGT_PTR_B_LOW:  pointer_b_low_q    <= req.wdata;
				TGT_PTR_B_SECT: pointer_b_sector_q <= req.wdata;
				TGT_PTR_C_LOW:  pointer_c_low_q    <= req.wdata;
				TGT_PTR_C_SECT: pointer_c_sector_q <= req.wdata;
				default: ;
			endcase
		end
	end

	// ==========================================================
	// alu flag calculation
	logic [DATA_W-1:0] add_sum;
	logic              add_carry;
	logic              add_nibble;
	logic              add_overflow;
	logic              add_zero;
	logic              add_signed;
	logic [DATA_W-1:0] alu_result;

	csr_flag_calc u_flag_calc (
		.a            (alu.a),
		.b            (alu.b),
		.cin          (alu.cin),
		.sub          (alu.op == CSR_OP_SUB),
		.sum          (add_sum),
		.carry        (add_carry),
		.nibble_carry (add_nibble),
		.overflow     (add_overflow),
		.zero         (add_zero),
		.signed_cmp   (add_signed)
	);

	assign alu_result = ((alu.op == CSR_OP_ADD) || (alu.op == CSR_OP_SUB)) ? add_sum
		: alu.logic_res;

	// ==========================================================
	// accumulator; alu result wins over a data write in the same cycle
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			acc_q <= RST_BYTE;
		end else if (clk_en && alu.valid && alu.dest_acc) begin
			acc_q <= alu_result; // see [RULE8]
		end else if (wr_en && (tgt == TGT_ACC)) begin
			acc_q <= req.wdata;
		end
	end

	// ==========================================================
	// program counter low byte: jump inside the current page
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			pc_load_q      <= 1'b0;
			pc_load_addr_q <= '0;
		end else if (clk_en) begin
			pc_load_q <= wr_en && (tgt == TGT_PC_LOW); // see [RULE10]
			if (wr_en && (tgt == TGT_PC_LOW)) begin
				pc_load_addr_q <= {pc_now[PC_W-1:8], req.wdata}; // see [RULE9]
			end
		end
	end

	// ==========================================================
	// look-up table pointer and result registers
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			table_pointer_low_q  <= RST_BYTE;
			table_pointer_high_q <= RST_BYTE;
		end else if (wr_en) begin
			if (tgt == TGT_TBL_LOW) begin
				table_pointer_low_q <= req.wdata;
			end
			if (tgt == TGT_TBL_HIGH) begin
				table_pointer_high_q <= req.wdata;
			end
		end
	end

	// the fetched word overrides a software write of the result register
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			table_result_high_q <= RST_BYTE;
			table_low_q         <= RST_BYTE;
			table_done_q        <= 1'b0;
		end else if (clk_en) begin
			table_done_q <= prog_valid;
			if (prog_valid) begin
				table_result_high_q <= prog_word[15:8]; // see [RULE11]
				table_low_q         <= prog_word[7:0];  // see [RULE11]
			end else if (wr_en && (tgt == TGT_TBL_RESULT)) begin
				table_result_high_q <= req.wdata;
			end
		end
	end

	// ==========================================================
	// status flags
	always_comb begin
		status_d = status_q;
		if (wr_en && (tgt == TGT_STATUS)) begin
			status_d = (status_q & ~ST_SW_MASK) | (req.wdata & ST_SW_MASK); // see [RULE12]
		end
		if (alu.valid) begin // see [RULE21]
			case (alu.op)
				CSR_OP_ADD, CSR_OP_SUB: begin
					if (alu.upd[UPD_CARRY])      status_d[ST_CARRY_BIT]      = add_carry;
					if (alu.upd[UPD_NIBBLE])     status_d[ST_NIBBLE_BIT]     = add_nibble;
					if (alu.upd[UPD_ZERO])       status_d[ST_ZERO_BIT]       = add_zero;
					if (alu.upd[UPD_OVERFLOW])   status_d[ST_OVERFLOW_BIT]   = add_overflow;
					if (alu.upd[UPD_SIGNED_CMP]) status_d[ST_SIGNED_CMP_BIT] = add_signed;
					if (alu.upd[UPD_CMP_ZERO])   status_d[ST_CMP_ZERO_BIT]   = add_zero;
				end
				default: begin
					if (alu.upd[UPD_ZERO]) begin
						status_d[ST_ZERO_BIT] = (alu_result == 8'h00); // see [RULE16]
					end
					if (alu.upd[UPD_CMP_ZERO]) begin
						status_d[ST_CMP_ZERO_BIT] = (alu_result == 8'h00);
					end
					if (alu.upd[UPD_SIGNED_CMP]) begin
						status_d[ST_SIGNED_CMP_BIT] = status_q[ST_OVERFLOW_BIT]
							^ alu_result[7]; // see [RULE13]
					end
					if ((alu.op == CSR_OP_ROTC) && alu.upd[UPD_CARRY]) begin
						status_d[ST_CARRY_BIT] = alu.rot_carry; // see [RULE14]
					end
				end
			endcase
		end
		// system flags: a set in the same cycle as a clear wins
		if (watchdog_clear_instruction) begin
			status_d[ST_POWER_DOWN_BIT]  = 1'b0; // see [RULE18]
			status_d[ST_WDT_EXPIRED_BIT] = 1'b0; // see [RULE19]
		end
		if (halt_instruction) begin
			status_d[ST_WDT_EXPIRED_BIT] = 1'b0; // see [RULE19]
			status_d[ST_POWER_DOWN_BIT]  = 1'b1; // see [RULE18]
		end
		if (watchdog_timeout) begin
			status_d[ST_WDT_EXPIRED_BIT] = 1'b1; // see [RULE19]
		end
	end

	// no call or interrupt input exists: saving flags is left to software
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			status_q <= RST_STATUS; // see [RULE18] [RULE19]
		end else if (clk_en) begin
			status_q <= status_d; // see [RULE20]
		end
	end

	// ==========================================================
	// outputs
	assign rsp_valid      = rsp_valid_q;
	assign rsp_rdata      = rsp_rdata_q;
	assign accumulator    = acc_q;
	assign status_flags   = status_q;
	assign pc_load        = pc_load_q;
	assign pc_load_addr   = pc_load_addr_q;
	assign dummy_cycle    = pc_load_q;
	assign table_addr     = {table_pointer_high_q, table_pointer_low_q};
	assign table_done     = table_done_q;
	assign table_low_byte = table_low_q;

endmodule

/* File: common/csr_pkg.sv */
// shared constants, types and carriers of the core special registers
package csr_pkg;

	// ==========================================================
	// widths
	localparam int DATA_W  = 8;
	localparam int ADDR_W  = 10;
	localparam int SECT_W  = 2;
	localparam int PC_W    = 13;
	localparam int PWORD_W = 16;
	localparam int TBL_W   = 16;

	// ==========================================================
	// special register offsets within every sector
	localparam logic [7:0] OFS_INDIRECT_PORT_A   = 8'h00;
	localparam logic [7:0] OFS_POINTER_A         = 8'h01;
	localparam logic [7:0] OFS_INDIRECT_PORT_B   = 8'h02;
	localparam logic [7:0] OFS_POINTER_B_LOW     = 8'h03;
	localparam logic [7:0] OFS_POINTER_B_SECTOR  = 8'h04;
	localparam logic [7:0] OFS_ACCUMULATOR       = 8'h05;
	localparam logic [7:0] OFS_PC_LOW_BYTE       = 8'h06;
	localparam logic [7:0] OFS_TABLE_POINTER_LOW = 8'h07;
	localparam logic [7:0] OFS_TABLE_RESULT_HIGH = 8'h08;
	localparam logic [7:0] OFS_TABLE_POINTER_HI  = 8'h09;
	localparam logic [7:0] OFS_STATUS_FLAGS      = 8'h0a;
	localparam logic [7:0] OFS_INDIRECT_PORT_C   = 8'h0c;
	localparam logic [7:0] OFS_POINTER_C_LOW     = 8'h0d;
	localparam logic [7:0] OFS_POINTER_C_SECTOR  = 8'h0e;

	// ==========================================================
	// status_flags bit positions
	localparam int ST_CARRY_BIT       = 0;
	localparam int ST_NIBBLE_BIT      = 1;
	localparam int ST_ZERO_BIT        = 2;
	localparam int ST_OVERFLOW_BIT    = 3;
	localparam int ST_POWER_DOWN_BIT  = 4;
	localparam int ST_WDT_EXPIRED_BIT = 5;
	localparam int ST_CMP_ZERO_BIT    = 6;
	localparam int ST_SIGNED_CMP_BIT  = 7;
	// bits that software writes may change
	localparam logic [7:0] ST_SW_MASK = 8'hcf;

	// flag update mask positions in the alu carrier
	localparam int UPD_CARRY      = 0;
	localparam int UPD_NIBBLE     = 1;
	localparam int UPD_ZERO       = 2;
	localparam int UPD_OVERFLOW   = 3;
	localparam int UPD_SIGNED_CMP = 4;
	localparam int UPD_CMP_ZERO   = 5;

	// ==========================================================
	// reset values
	localparam logic [7:0] RST_BYTE   = 8'h00;
	localparam logic [7:0] RST_STATUS = 8'h00;

	// ==========================================================
	// enumerations
	typedef enum logic [1:0] {
		CSR_OP_ADD,
		CSR_OP_SUB,
		CSR_OP_LOGIC,
		CSR_OP_ROTC
	} csr_op_t;

	typedef enum logic [3:0] {
		TGT_EXTERNAL,
		TGT_IND_A,
		TGT_IND_B,
		TGT_IND_C,
		TGT_PTR_A,
		TGT_PTR_B_LOW,
		TGT_PTR_B_SECT,
		TGT_PTR_C_LOW,
		TGT_PTR_C_SECT,
		TGT_ACC,
		TGT_PC_LOW,
		TGT_TBL_LOW,
		TGT_TBL_HIGH,
		TGT_TBL_RESULT,
		TGT_STATUS
	} csr_target_t;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic              valid;
		logic              write;
		logic              ext;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} csr_req_t;

	typedef struct packed {
		logic              valid;
		csr_op_t           op;
		logic [DATA_W-1:0] a;
		logic [DATA_W-1:0] b;
		logic              cin;
		logic [DATA_W-1:0] logic_res;
		logic              rot_carry;
		logic              dest_acc;
		logic [5:0]        upd;
	} csr_alu_t;

endpackage

/* File: rtl/csr_flag_calc.sv */
// adder with carry, nibble carry, overflow, zero and signed-compare outputs
`timescale 1ns/1ns
module csr_flag_calc
	import csr_pkg::*;
(
	// operands
	input  wire logic [DATA_W-1:0] a,
	input  wire logic [DATA_W-1:0] b,
	input  wire logic              cin,
	input  wire logic              sub,
	// results
	output logic      [DATA_W-1:0] sum,
	output logic                   carry,
	output logic                   nibble_carry,
	output logic                   overflow,
	output logic                   zero,
	output logic                   signed_cmp
);

	logic [DATA_W-1:0] b_eff;
	logic [4:0]        low_sum;
	logic [7:0]        low7_sum;
	logic [8:0]        full_sum;

	// subtraction adds the complement, so carry out means no borrow
	assign b_eff    = sub ? ~b : b;
	assign low_sum  = {1'b0, a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
	assign low7_sum = {1'b0, a[6:0]} + {1'b0, b_eff[6:0]} + {7'h00, cin};
	assign full_sum = {1'b0, a} + {1'b0, b_eff} + {8'h00, cin};

	assign sum          = full_sum[7:0];
	assign carry        = full_sum[8];              // see [RULE14]
	assign nibble_carry = low_sum[4];               // see [RULE15]
	assign overflow     = low7_sum[7] ^ full_sum[8]; // see [RULE17]
	assign zero         = (full_sum[7:0] == 8'h00); // see [RULE16]
	assign signed_cmp   = overflow ^ full_sum[7];   // see [RULE13]

endmodule

/* File: verification/csr_core_special_registers_sva.sv */
// assertions on the ports of the core special registers
`timescale 1ns/1ns
module csr_core_special_registers_sva
	import csr_pkg::*;
(
	// clock and reset
	input wire logic              clock,
	input wire logic              reset_n,
	input wire logic              clk_en,
	// watched ports
	input wire csr_req_t          req,
	input wire logic              mem_en,
	input wire logic [ADDR_W-1:0] mem_addr,
	input wire csr_alu_t          alu,
	input wire logic [DATA_W-1:0] status_flags,
	input wire logic [PC_W-1:0]   pc_now,
	input wire logic              pc_load,
	input wire logic [PC_W-1:0]   pc_load_addr,
	input wire logic              dummy_cycle,
	input wire logic              prog_valid,
	input wire logic [PWORD_W-1:0] prog_word,
	input wire logic              table_done,
	input wire logic [DATA_W-1:0] table_low_byte,
	input wire logic              watchdog_clear_instruction,
	input wire logic              halt_instruction,
	input wire logic              watchdog_timeout
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	// ==========================================================
	// helper logic
	logic [7:0] b_eff;
	logic [8:0] sum9;
	logic       arith, sw_st;
	assign b_eff = (alu.op == CSR_OP_SUB) ? ~alu.b : alu.b;
	assign sum9  = {1'b0, alu.a} + {1'b0, b_eff} + {8'h00, alu.cin};
	assign arith = clk_en && alu.valid && (alu.op == CSR_OP_ADD || alu.op == CSR_OP_SUB);
	assign sw_st = clk_en && req.valid && req.write && req.addr[7:0] == OFS_STATUS_FLAGS
		&& !alu.valid && !halt_instruction && !watchdog_timeout && !watchdog_clear_instruction;
	// ==========================================================
	// properties
	chk_ind_a_sector: assert property (
		req.valid && req.addr[7:0] == OFS_INDIRECT_PORT_A && mem_en |-> mem_addr[9:8] == 2'b00)
		else $error("indirect port a left sector 0");
	chk_ext_direct: assert property (
		clk_en && req.valid && req.ext && req.addr[7:0] >= 8'h10
		|-> mem_en && mem_addr == req.addr)
		else $error("extended address not passed through");
	chk_pc_jump: assert property (
		clk_en && req.valid && req.write && req.addr[7:0] == OFS_PC_LOW_BYTE
		|=> pc_load && pc_load_addr == {$past(pc_now[12:8]), $past(req.wdata)})
		else $error("jump target wrong");
	chk_dummy_pc: assert property (
		clk_en && !req.valid |=> !dummy_cycle && !pc_load)
		else $error("dummy cycle without a jump");
	chk_status_sw: assert property (
		sw_st |=> status_flags == (($past(req.wdata) & ST_SW_MASK)
		| ($past(status_flags) & ~ST_SW_MASK)))
		else $error("status write wrong");
	chk_halt_flags: assert property (
		clk_en && halt_instruction && !watchdog_timeout
		|=> status_flags[ST_POWER_DOWN_BIT] && !status_flags[ST_WDT_EXPIRED_BIT])
		else $error("halt flags wrong");
	chk_timeout_set: assert property (
		clk_en && watchdog_timeout |=> status_flags[ST_WDT_EXPIRED_BIT])
		else $error("time-out flag not set");
	chk_signed_cmp: assert property (
		arith && alu.upd[4] && alu.upd[3]
		|=> status_flags[7] == (status_flags[3] ^ $past(sum9[7])))
		else $error("signed compare flag wrong");
	chk_carry_add: assert property (
		arith && alu.upd[0] |=> status_flags[ST_CARRY_BIT] == $past(sum9[8]))
		else $error("carry flag wrong");
	chk_table_load: assert property (
		clk_en && prog_valid |=> table_done && table_low_byte == $past(prog_word[7:0]))
		else $error("table low byte wrong");
endmodule

bind csr_core_special_registers csr_core_special_registers_sva csr_core_special_registers_sva_inst (
	.clock, .reset_n, .clk_en, .req, .mem_en, .mem_addr, .alu, .status_flags, .pc_now,
	.pc_load, .pc_load_addr, .dummy_cycle, .prog_valid, .prog_word, .table_done,
	.table_low_byte, .watchdog_clear_instruction, .halt_instruction, .watchdog_timeout
);

/* File: verification/csr_mem_model.sv */
// data memory array model on the far side of the core special registers
`timescale 1ns/1ns
module csr_mem_model
	import csr_pkg::*;
(
	// clock
	input  wire logic              clock,
	// memory port
	input  wire logic              mem_en,
	input  wire logic              mem_we,
	input  wire logic [ADDR_W-1:0] mem_addr,
	input  wire logic [DATA_W-1:0] mem_wdata,
	output logic      [DATA_W-1:0] mem_rdata
);
	logic [DATA_W-1:0] mem [0:1023];
	logic [DATA_W-1:0] last_q = 8'h00;
	initial begin
		for (int i = 0; i < 1024; i++) begin
			mem[i] = 8'(i) ^ 8'h5a;
		end
	end
	// an unselected array must not look as if it still holds the last byte
	assign mem_rdata = mem_en ? mem[mem_addr] : ~last_q;
	always @(posedge clock) begin
		if (mem_en) begin
			last_q <= mem_rdata;
		end
		if (mem_en && mem_we) begin
			mem[mem_addr] <= mem_wdata;
		end
	end
endmodule

/* File: verification/csr_core_special_registers_tb.sv */
// self-checking bench for the core special registers
`timescale 1ns/1ns
module csr_core_special_registers_tb
	import csr_pkg::*;
;
	// ==========================================================
	// signals
	logic              clock = 1'b0, reset_n = 1'b0, clk_en = 1'b1;
	csr_req_t          req = '0;
	csr_alu_t          alu = '0;
	logic [PC_W-1:0]   pc_now = '0, pc_load_addr;
	logic              prog_valid = 1'b0, watchdog_clear_instruction = 1'b0;
	logic [PWORD_W-1:0] prog_word = '0;
	logic              halt_instruction = 1'b0, watchdog_timeout = 1'b0;
	logic              rsp_valid, mem_en, mem_we, pc_load, dummy_cycle, table_done;
	logic [DATA_W-1:0] rsp_rdata, mem_wdata, mem_rdata, accumulator, status_flags;
	logic [DATA_W-1:0] table_low_byte, rd, x, y, a, b, bb, am, st_m;
	logic [ADDR_W-1:0] mem_addr;
	logic [TBL_W-1:0]  table_addr;
	logic              ci, rc, ov;
	int                fails = 0, tests_run = 0, cycles = 0, seed = 32'h44ac1b6a;
	int                s, n, c7, k;
	logic [7:0]        ptrs [5] = '{OFS_POINTER_A, OFS_POINTER_B_LOW, OFS_POINTER_B_SECTOR,
		OFS_POINTER_C_LOW, OFS_POINTER_C_SECTOR};

	always #20 clock = ~clock;

	csr_core_special_registers csr_core_special_registers_inst (.clock, .reset_n, .clk_en,
		.req, .rsp_valid, .rsp_rdata, .mem_en, .mem_we, .mem_addr, .mem_wdata, .mem_rdata,
		.alu, .accumulator, .status_flags, .pc_now, .pc_load, .pc_load_addr, .dummy_cycle,
		.table_addr, .prog_valid, .prog_word, .table_done, .table_low_byte,
		.watchdog_clear_instruction, .halt_instruction, .watchdog_timeout);
	csr_mem_model csr_mem_model_inst (.clock, .mem_en, .mem_we, .mem_addr, .mem_wdata,
		.mem_rdata);

	// ==========================================================
	// tasks
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// one request, held for one clock edge, then dropped
	task automatic acc(input logic wr, input logic [9:0] addr, input logic [7:0] wd);
		@(posedge clock);
		req <= '{1'b1, wr, |addr[9:8], addr, wd};
		@(posedge clock);
		req.valid <= 1'b0;
		#1;
		rd = rsp_rdata;
		if (!wr) check("rsp_valid", rsp_valid, 1'b1);
	endtask
	task automatic sysev(input logic h, input logic t, input logic c);
		@(posedge clock);
		{halt_instruction, watchdog_timeout, watchdog_clear_instruction} <= {h, t, c};
		@(posedge clock);
		{halt_instruction, watchdog_timeout, watchdog_clear_instruction} <= 3'b000;
		#1;
	endtask

	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			fails++;
			end_of_test();
		end
	end

	// ==========================================================
	// scenarios
	initial begin
		repeat (2) @(posedge clock);
		reset_n <= 1'b1;
		#1;
		check("status reset", status_flags, RST_STATUS);
		foreach (ptrs[i]) begin
			x = 8'($random(seed));
			acc(1, 10'(ptrs[i]), x);
			acc(0, 10'(ptrs[i]), 8'h00);
			check("pointer", rd, x);
		end
		x = 8'h80 | 8'($random(seed));
		y = 8'($random(seed));
		acc(1, 10'(OFS_POINTER_A), x);
		clk_en <= 1'b0;
		acc(1, 10'(OFS_POINTER_A), ~x);
		clk_en <= 1'b1;
		acc(1, 10'h200, y);
		check("port a write", csr_mem_model_inst.mem[{2'b00, x}], y);
		acc(0, 10'h000, 8'h00);
		check("port a read", rd, y);
		for (int p = 0; p < 2; p++) begin
			for (int sc = 0; sc < 4; sc++) begin
				x = 8'h80 | 8'($random(seed));
				y = 8'($random(seed));
				acc(1, 10'(p ? OFS_POINTER_C_SECTOR : OFS_POINTER_B_SECTOR), 8'(sc));
				acc(1, 10'(p ? OFS_POINTER_C_LOW : OFS_POINTER_B_LOW), x);
				acc(1, 10'(p ? OFS_INDIRECT_PORT_C : OFS_INDIRECT_PORT_B), y);
				check("port write", csr_mem_model_inst.mem[{2'(sc), x}], y);
				acc(0, {2'(sc), x}, 8'h00);
				check("direct read", rd, y);
			end
		end
		acc(1, 10'(OFS_POINTER_B_LOW), OFS_INDIRECT_PORT_C);
		acc(0, 10'(OFS_INDIRECT_PORT_B), 8'h00);
		check("port on port", rd, 8'h00);
		pc_now <= 13'($random(seed));
		x = 8'($random(seed));
		acc(1, 10'(OFS_PC_LOW_BYTE), x);
		check("jump pulse", {pc_load, dummy_cycle}, 2'b11);
		check("jump target", pc_load_addr, {pc_now[12:8], x});
		x = 8'($random(seed));
		y = 8'($random(seed));
		acc(1, 10'(OFS_TABLE_POINTER_LOW), x);
		acc(1, 10'(OFS_TABLE_POINTER_HI), y);
		check("table addr", table_addr, {y, x});
		@(posedge clock);
		{prog_valid, prog_word} <= {1'b1, 16'($random(seed))};
		@(posedge clock);
		prog_valid <= 1'b0;
		#1;
		check("table low", {table_done, table_low_byte}, {1'b1, prog_word[7:0]});
		acc(0, 10'(OFS_TABLE_RESULT_HIGH), 8'h00);
		check("table high", rd, prog_word[15:8]);
		sysev(0, 1, 0);
		check("time-out", status_flags[5:4], 2'b10);
		sysev(1, 0, 0);
		check("halt", status_flags[5:4], 2'b01);
		sysev(0, 1, 0);
		acc(1, 10'(OFS_STATUS_FLAGS), 8'h00);
		check("status write 00", status_flags, 8'h30);
		acc(1, 10'(OFS_STATUS_FLAGS), 8'hff);
		check("status write ff", status_flags, 8'hff);
		sysev(0, 0, 1);
		check("clear", status_flags, 8'hcf);
		st_m = 8'hcf;
		for (int i = 0; i < 30; i++) begin
			k = i % 4;
			a = 8'($random(seed));
			b = 8'($random(seed));
			ci = 1'($random(seed));
			rc = 1'($random(seed));
			@(posedge clock);
			alu <= '{1'b1, csr_op_t'(k), a, b, ci, a, rc, 1'b1,
				k == 3 ? 6'h01 : 6'h3f};
			@(posedge clock);
			alu.valid <= 1'b0;
			#1;
			bb = (k == 1) ? ~b : b;
			s = a + bb + ci;
			n = a[3:0] + bb[3:0] + ci;
			c7 = a[6:0] + bb[6:0] + ci;
			if (k < 2) begin
				ov = c7[7] ^ s[8];
				st_m = {ov ^ s[7], s[7:0] == 0, st_m[5:4], ov, s[7:0] == 0, n > 15, s > 255};
			end else begin
				st_m = (k == 3) ? {st_m[7:1], rc}
					: {st_m[3] ^ a[7], a == 0, st_m[5:3], a == 0, st_m[1:0]};
			end
			am = (k < 2) ? s[7:0] : a;
			check("flags", status_flags, st_m);
			check("accumulator", accumulator, am);
		end
		end_of_test();
	end
endmodule
